// ### verilog/drc_ctrl.sv
// Controller driving a multiplexed-address 4K x 1 dynamic memory by its strobes
`timescale 1ns/1ps
`default_nettype none
module drc_ctrl #(
   parameter int REF_CYC = drc_pkg::REF_CYC
) (
   // Clock and reset
   input  wire logic                       sys_clk_i,
   input  wire logic                       rstn_i,
   input  wire logic                       ce_i,
   // User request
   input  wire logic                       req_valid_i,
   input  wire drc_pkg::drc_req_type       req_i,
   output logic                            req_ready_o,
   output logic                            rsp_valid_o,
   output logic                            rsp_data_o,
   output logic                            refresh_busy_o,
   // Memory pins
   output var drc_pkg::drc_strobe_type     strobe_o,
   output logic [drc_pkg::HALF_W-1:0]      mem_addr_o,
   output logic                            mem_din_o,
   input  wire logic                       mem_dout_i
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ROW,
      ST_COL,
      ST_ACCESS,
      ST_WRITE,
      ST_PRECHARGE
   } drc_state_type;

   drc_state_type              state_reg;
   drc_pkg::drc_req_type       cur_reg;
   logic                       is_ref_reg;
   logic [drc_pkg::CNT_W-1:0]  cnt_reg;
   logic                       ref_due;
   logic                       ref_done;
   logic [drc_pkg::HALF_W-1:0] ref_row;

   function automatic logic cnt_last(input logic [drc_pkg::CNT_W-1:0] c,
                                     input logic [drc_pkg::CNT_W-1:0] n);
      cnt_last = (c >= n - 1'b1);
   endfunction

   // Refresh demand is cleared as soon as the sequencer takes it
   assign ref_done = ce_i && (state_reg == ST_IDLE) && ref_due;

   drc_refresh_timer #(
      .REF_CYC (REF_CYC)
   ) u_refresh (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .ce_i      (ce_i),
      .done_i    (ref_done),
      .due_o     (ref_due),
      .row_o     (ref_row)
   );

   // Sequencer
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg  <= ST_IDLE;
         cnt_reg    <= '0;
         is_ref_reg <= 1'b0;
         cur_reg    <= '0;
      end else if (ce_i) begin
         cnt_reg <= cnt_reg + 1'b1;
         unique case (state_reg)
            ST_IDLE: begin
               cnt_reg <= '0;
               if (ref_due) begin
                  state_reg  <= ST_ROW;
                  is_ref_reg <= 1'b1;
                  cur_reg.op    <= drc_pkg::DRC_OP_READ;
                  cur_reg.addr  <= {ref_row, {drc_pkg::HALF_W{1'b0}}};
                  cur_reg.wdata <= 1'b0;
               end else if (req_valid_i) begin
                  state_reg  <= ST_ROW;
                  is_ref_reg <= 1'b0;
                  cur_reg    <= req_i;
               end
            end
            ST_ROW: begin
               if (cnt_last(cnt_reg, drc_pkg::RCL_CYC)) begin
                  state_reg <= ST_COL;
                  cnt_reg   <= '0;
               end
            end
            ST_COL: begin
               state_reg <= (cur_reg.op == drc_pkg::DRC_OP_WRITE) ? ST_WRITE : ST_ACCESS;
               cnt_reg   <= '0;
            end
            ST_ACCESS: begin
               if (cnt_last(cnt_reg, drc_pkg::CAC_CYC)) begin
                  cnt_reg   <= '0;
                  state_reg <= (cur_reg.op == drc_pkg::DRC_OP_RMW) ? ST_WRITE
                                                                   : ST_PRECHARGE;
               end
            end
            ST_WRITE: begin
               if (cnt_last(cnt_reg, drc_pkg::WCH_CYC)) begin
                  state_reg <= ST_PRECHARGE;
                  cnt_reg   <= '0;
               end
            end
            ST_PRECHARGE: begin
               if (cnt_last(cnt_reg, drc_pkg::RP_CYC)) begin
                  state_reg <= ST_IDLE;
                  cnt_reg   <= '0;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Pin drive, registered from the current state
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         strobe_o   <= '{ras_n: 1'b1, cas_n: 1'b1, write_n: 1'b1, cs_n: 1'b0};
         mem_addr_o <= '0;
         mem_din_o  <= 1'b0;
      end else if (ce_i) begin
         strobe_o.cs_n <= 1'b0;
         unique case (state_reg)
            ST_IDLE: begin
               strobe_o.ras_n   <= 1'b1;
               strobe_o.cas_n   <= 1'b1;
               strobe_o.write_n <= 1'b1;
               if (ref_due) begin
                  mem_addr_o <= ref_row;
               end else if (req_valid_i) begin
                  mem_addr_o <= req_i.addr[drc_pkg::ADDR_W-1:drc_pkg::HALF_W];
                  mem_din_o  <= req_i.wdata;
               end
            end
            ST_ROW: begin
               strobe_o.ras_n <= 1'b0;
               if (cnt_last(cnt_reg, drc_pkg::RCL_CYC)) begin
                  mem_addr_o <= cur_reg.addr[drc_pkg::HALF_W-1:0];
                  if (cur_reg.op == drc_pkg::DRC_OP_WRITE) begin
                     strobe_o.write_n <= 1'b0;
                  end
               end
            end
            ST_COL: begin
               strobe_o.cas_n <= 1'b0;
            end
            ST_ACCESS: begin
               if (cnt_last(cnt_reg, drc_pkg::CAC_CYC)
                   && cur_reg.op == drc_pkg::DRC_OP_RMW) begin
                  strobe_o.write_n <= 1'b0;
               end
            end
            ST_WRITE: begin
               if (cnt_last(cnt_reg, drc_pkg::WCH_CYC)) begin
                  strobe_o.ras_n   <= 1'b1;
                  strobe_o.cas_n   <= 1'b1;
                  strobe_o.write_n <= 1'b1;
               end
            end
            ST_PRECHARGE: begin
               strobe_o.ras_n   <= 1'b1;
               strobe_o.cas_n   <= 1'b1;
               strobe_o.write_n <= 1'b1;
            end
            default: strobe_o.ras_n <= 1'b1;
         endcase
      end
   end

   // User handshake and read data capture
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         req_ready_o    <= 1'b0;
         rsp_valid_o    <= 1'b0;
         rsp_data_o     <= 1'b0;
         refresh_busy_o <= 1'b0;
      end else if (ce_i) begin
         req_ready_o    <= (state_reg == ST_IDLE) && !ref_due && !req_valid_i;
         refresh_busy_o <= ref_due || is_ref_reg && (state_reg != ST_IDLE);
         rsp_valid_o    <= 1'b0;
         if (state_reg == ST_ACCESS && cnt_last(cnt_reg, drc_pkg::CAC_CYC)
             && !is_ref_reg) begin
            rsp_valid_o <= 1'b1;
            rsp_data_o  <= mem_dout_i;
         end else if (state_reg == ST_WRITE && cnt_last(cnt_reg, drc_pkg::WCH_CYC)
                      && cur_reg.op == drc_pkg::DRC_OP_WRITE && !is_ref_reg) begin
            rsp_valid_o <= 1'b1;
         end
      end
   end

   // Checks
   sequence s_row_low;
      !strobe_o.ras_n && strobe_o.cas_n;
   endsequence

   AST_RAS_BEFORE_CAS: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $fell(strobe_o.cas_n) |-> $past(!strobe_o.ras_n))
      else $error("column strobe fell without row strobe low");

   AST_ROW_LEAD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $fell(strobe_o.ras_n) |-> s_row_low [*3])
      else $error("column strobe too soon after row strobe");

   AST_CS_LOW: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !strobe_o.cs_n)
      else $error("chip select not held low");

   AST_END_BOTH_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(strobe_o.ras_n) |-> strobe_o.cas_n && strobe_o.write_n)
      else $error("row strobe rose with other strobes low");

   AST_WRITE_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i || !ce_i)
      ($fell(strobe_o.cas_n) && !strobe_o.write_n) |-> (!strobe_o.cas_n)[*3])
      else $error("write pulse too short");

   AST_RAS_RELATION: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      strobe_o.ras_n |-> strobe_o.cas_n)
      else $error("column strobe low in standby");

   AST_ADDR_STABLE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      $fell(strobe_o.ras_n) |-> $stable(mem_addr_o))
      else $error("address moved at row strobe");

   AST_REF_READ: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (is_ref_reg && state_reg != ST_IDLE) |-> strobe_o.write_n)
      else $error("write during refresh");

   AST_RSP_AFTER_ACCESS: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (rsp_valid_o && cur_reg.op != drc_pkg::DRC_OP_WRITE)
      |-> !strobe_o.cas_n && $past(!strobe_o.cas_n, 4))
      else $error("read data taken before access time");
endmodule
`default_nettype wire

// ### verilog/drc_pkg.sv
// Constants and types for the strobe-driven 4K x 1 dynamic memory controller
package drc_pkg;
   localparam int ADDR_W      = 12;
   localparam int HALF_W      = 6;
   localparam int ROWS        = 64;
   localparam int CLK_NS      = 50;
   // Strobe timing in ns, refresh period in ms
   localparam int T_RCL_NS    = 110;
   localparam int T_CPW_NS    = 200;
   localparam int T_CAC_NS    = 200;
   localparam int T_WCH_NS    = 150;
   localparam int T_RP_NS     = 125;
   localparam int T_MOD_NS    = 10;
   localparam int T_REF_MS    = 2;
   localparam int CNT_W       = 4;
   // Derived cycle counts, minimum times round up
   localparam logic [CNT_W-1:0] RCL_CYC = CNT_W'((T_RCL_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] CPW_CYC = CNT_W'((T_CPW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] CAC_CYC = CNT_W'((T_CAC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] WCH_CYC = CNT_W'((T_WCH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] RP_CYC  = CNT_W'((T_RP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] MOD_CYC = CNT_W'((T_MOD_NS + CLK_NS - 1) / CLK_NS);
   // Refresh budget: 2 ms over 64 rows, longest time rounds down
   localparam int REF_CYC     = (T_REF_MS * 1000000 / CLK_NS) / ROWS;
   localparam int REF_W       = 12;

   typedef enum logic [1:0] {
      DRC_OP_READ,
      DRC_OP_WRITE,
      DRC_OP_RMW
   } drc_op_type;

   typedef struct packed {
      drc_op_type        op;
      logic [ADDR_W-1:0] addr;
      logic              wdata;
   } drc_req_type;

   typedef struct packed {
      logic ras_n;
      logic cas_n;
      logic write_n;
      logic cs_n;
   } drc_strobe_type;
endpackage

// ### verilog/drc_refresh_timer.sv
// Refresh interval timer and row counter
`timescale 1ns/1ps
`default_nettype none
module drc_refresh_timer #(
   parameter int REF_CYC = drc_pkg::REF_CYC
) (
   // Clock and reset
   input  wire logic                     sys_clk_i,
   input  wire logic                     rstn_i,
   input  wire logic                     ce_i,
   // Control
   input  wire logic                     done_i,
   output logic                          due_o,
   output logic [drc_pkg::HALF_W-1:0]    row_o
);
   localparam int REF_W = drc_pkg::REF_W;
   // Longest wait of a due refresh behind a running cycle, in clocks
   localparam int SLACK = 3 + int'(drc_pkg::RCL_CYC) + int'(drc_pkg::CAC_CYC)
                          + int'(drc_pkg::WCH_CYC) + int'(drc_pkg::RP_CYC);
   // Period shortened by that wait so a late start still keeps every row in budget
   localparam logic [REF_W-1:0] LAST = REF_W'(REF_CYC - SLACK - 1);

   logic [REF_W-1:0] cnt_reg;

   // Free-running period; done_i marks a refresh taken, a new period end wins over it
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_reg <= '0;
         due_o   <= 1'b0;
      end else if (ce_i) begin
         if (cnt_reg >= LAST) begin
            cnt_reg <= '0;
            due_o   <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
            if (done_i) begin
               due_o <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         row_o <= '0;
      end else if (ce_i && done_i) begin
         row_o <= row_o + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### tb/drc_mem_model.sv
// Behavioural 4K x 1 strobe-driven dynamic memory facing the controller
`timescale 1ns/1ps
`default_nettype none
module drc_mem_model #(
   parameter int T_ACC_NS = 140
) (
   // Memory pins
   input  wire drc_pkg::drc_strobe_type strobe_i,
   input  wire logic [5:0]              addr_i,
   input  wire logic                    din_i,
   output logic                         dout_o,
   // Observation
   output int                           viol_o,
   output int                           max_gap_o,
   output int                           rows_seen_o
);
   logic       cells [4096];
   logic [5:0] row_q;
   logic [5:0] col_q;
   logic       act = 1'b0;
   logic       sel = 1'b0;
   logic       early = 1'b0;
   logic       drv = 1'b0;
   logic       last = 1'b0;
   bit         seen [64];
   int         last_ns [64] = '{default: 0};
   int         t_ov = -1;
   int         t_rise = -1000;

   function automatic int now_ns();
      return int'($time);
   endfunction

   initial begin
      viol_o = 0;
      max_gap_o = 0;
      rows_seen_o = 0;
   end

   // A floating output shows the inverse of what it last drove
   assign dout_o = drv ? last : ~last;

   always @(negedge strobe_i.ras_n) begin
      if (now_ns() - t_rise < drc_pkg::T_RP_NS)
         viol_o++;
      row_q = addr_i;
      act = 1'b1;
      if (!seen[row_q])
         rows_seen_o++;
      seen[row_q] = 1'b1;
      if (now_ns() - last_ns[row_q] > max_gap_o)
         max_gap_o = now_ns() - last_ns[row_q];
      last_ns[row_q] = now_ns();
   end

   always @(posedge strobe_i.ras_n) begin
      act = 1'b0;
      t_rise = now_ns();
   end

   always @(negedge strobe_i.cas_n) begin
      col_q = addr_i;
      sel = act && !strobe_i.cs_n;
      drv = 1'b0;
      early = !strobe_i.write_n;
      if (early)
         t_ov = now_ns();
      if (early && sel)
         cells[{row_q, col_q}] = din_i;
      #(T_ACC_NS);
      if (!strobe_i.cas_n && sel) begin
         last = early ? 1'b1 : cells[{row_q, col_q}];
         drv = 1'b1;
      end
   end

   always @(negedge strobe_i.write_n) begin
      if (!strobe_i.cas_n)
         t_ov = now_ns();
      if (!strobe_i.cas_n && sel)
         cells[{row_q, col_q}] = din_i;
   end

   always @(posedge strobe_i.write_n or posedge strobe_i.cas_n) begin
      if (t_ov >= 0 && now_ns() - t_ov < drc_pkg::T_WCH_NS)
         viol_o++;
      t_ov = -1;
   end
endmodule
`default_nettype wire

// ### tb/drc_ctrl_bench.sv
// Self-checking bench for the strobe-driven dynamic memory controller
`timescale 1ns/1ps
`default_nettype none
module drc_ctrl_bench;
   localparam int REF_C = 40;
   localparam int WIN_NS = drc_pkg::ROWS * REF_C * drc_pkg::CLK_NS;
   logic                    sys_clk_i;
   logic                    rstn_i;
   logic                    ce_i;
   logic                    req_valid_i;
   drc_pkg::drc_req_type    req_i;
   logic                    req_ready_o;
   logic                    rsp_valid_o;
   logic                    rsp_data_o;
   logic                    refresh_busy_o;
   drc_pkg::drc_strobe_type strobe_o;
   logic [5:0]              mem_addr_o;
   logic                    mem_din_o;
   logic                    mem_dout_i;
   int                      viol;
   int                      max_gap;
   int                      rows_seen;
   int                      mismatches = 0;
   int                      n_compared = 0;
   logic [11:0]             tab [8] = '{12'h000, 12'hfff, 12'h03f, 12'hfc0,
                                        12'h041, 12'h820, 12'h555, 12'haaa};

   drc_ctrl #(.REF_CYC(REF_C)) u_drc_ctrl (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .ce_i(ce_i), .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
      .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .refresh_busy_o(refresh_busy_o),
      .strobe_o(strobe_o), .mem_addr_o(mem_addr_o), .mem_din_o(mem_din_o),
      .mem_dout_i(mem_dout_i));
   drc_mem_model u_drc_mem_model (.strobe_i(strobe_o), .addr_i(mem_addr_o),
      .din_i(mem_din_o), .dout_o(mem_dout_i), .viol_o(viol), .max_gap_o(max_gap),
      .rows_seen_o(rows_seen));

   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   task automatic check_bit(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic check_le(input int got, input int lim, input string what);
      n_compared++;
      if (got > lim) begin
         mismatches++;
         $display("MISMATCH t=%0t %s %0d above %0d", $time, what, got, lim);
      end
   endtask

   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One request held until its response pulse
   task automatic access(input drc_pkg::drc_op_type op, input logic [11:0] a,
                         input logic d, output logic q);
      int n;
      @(posedge sys_clk_i);
      for (n = 0; n < 100 && req_ready_o !== 1'b1; n++)
         @(posedge sys_clk_i);
      check_bit(req_ready_o, 1'b1, "ready");
      req_valid_i <= 1'b1;
      req_i <= '{op, a, d};
      for (n = 0; n < 200 && rsp_valid_o !== 1'b1; n++)
         @(posedge sys_clk_i);
      check_bit(rsp_valid_o, 1'b1, "response");
      q = rsp_data_o;
      req_valid_i <= 1'b0;
   endtask

   // Every column strobe comes inside a row strobe with select held low
   always @(negedge strobe_o.cas_n) begin
      check_bit(strobe_o.ras_n, 1'b0, "row strobe lead");
      check_bit(strobe_o.cs_n, 1'b0, "select low");
   end

   task automatic t_map();
      logic q;
      for (int i = 0; i < 8; i++)
         access(drc_pkg::DRC_OP_WRITE, tab[i], i[0], q);
      for (int i = 0; i < 8; i++) begin
         access(drc_pkg::DRC_OP_READ, tab[i], 1'b0, q);
         check_bit(q, i[0], "read back");
         access(drc_pkg::DRC_OP_READ, tab[i], 1'b0, q);
         check_bit(q, i[0], "second read");
      end
      $display("done: address map");
   endtask

   task automatic t_rmw();
      logic q;
      drc_pkg::drc_strobe_type s;
      // Clock enable dropped in mid-cycle must freeze the strobes
      fork
         access(drc_pkg::DRC_OP_RMW, 12'h555, 1'b1, q);
         begin
            repeat (6) @(posedge sys_clk_i);
            ce_i <= 1'b0;
            @(posedge sys_clk_i);
            s = strobe_o;
            repeat (3) @(posedge sys_clk_i);
            check_bit(strobe_o == s, 1'b1, "frozen strobes");
            ce_i <= 1'b1;
         end
      join
      check_bit(q, 1'b0, "rmw old");
      access(drc_pkg::DRC_OP_READ, 12'h555, 1'b0, q);
      check_bit(q, 1'b1, "rmw new");
      access(drc_pkg::DRC_OP_RMW, 12'h555, 1'b0, q);
      check_bit(q, 1'b1, "rmw old again");
      access(drc_pkg::DRC_OP_WRITE, 12'hfff, 1'b0, q);
      access(drc_pkg::DRC_OP_READ, 12'h555, 1'b0, q);
      check_bit(q, 1'b0, "rmw cleared");
      access(drc_pkg::DRC_OP_READ, 12'hfff, 1'b0, q);
      check_bit(q, 1'b0, "write after write");
      $display("done: read-modify-write");
   endtask

   task automatic t_refresh();
      logic q;
      logic busy_seen;
      busy_seen = 1'b0;
      repeat (WIN_NS / drc_pkg::CLK_NS + 100) begin
         @(posedge sys_clk_i);
         busy_seen = busy_seen | (refresh_busy_o === 1'b1);
      end
      check_bit(busy_seen, 1'b1, "refresh ran");
      check_le(64, rows_seen, "rows refreshed");
      check_le(max_gap, WIN_NS, "refresh gap");
      check_le(viol, 0, "strobe timing");
      access(drc_pkg::DRC_OP_READ, tab[3], 1'b0, q);
      check_bit(q, 1'b1, "kept through refresh");
      $display("done: refresh");
   endtask

   initial begin
      rstn_i = 1'b0;
      ce_i = 1'b1;
      req_valid_i = 1'b0;
      req_i = '0;
      repeat (3) @(posedge sys_clk_i);
      check_bit(strobe_o.ras_n, 1'b1, "reset row strobe");
      check_bit(strobe_o.cas_n, 1'b1, "reset column strobe");
      check_bit(rsp_valid_o, 1'b0, "reset response");
      rstn_i <= 1'b1;
      $display("done: reset");
      t_map();
      t_rmw();
      t_refresh();
      tally_and_finish();
   end

   initial begin
      #(WIN_NS * 3);
      mismatches++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
`default_nettype wire
